// ---- src/cbf_exec.sv ----
// Executor for flag branches, I/O bit ops, shifts, bit transfer, flag ops
`timescale 1ns/1ps
module cbf_exec
  import cbf_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_valid,
  input  cbf_pkg::cbf_op_t           i_op,
  input  wire logic [6:0]            i_k,
  input  wire logic [2:0]            i_bit,
  input  wire logic [4:0]            i_io_addr,
  input  wire logic [7:0]            i_rd_data,
  input  wire logic [7:0]            i_io_rdata,
  output logic                       o_ready,
  output logic [cbf_pkg::PC_W-1:0]   o_pc,
  output logic [7:0]                 o_status_flags_register,
  output logic                       o_rd_we,
  output logic [7:0]                 o_rd_wdata,
  output logic                       o_io_re,
  output logic                       o_io_we,
  output logic [4:0]                 o_io_addr,
  output logic [7:0]                 o_io_wdata
);

  import cbf_pkg::*;

  cbf_state_t      state_reg;
  logic            ready_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [7:0]      status_flags_register_reg;
  logic            rd_we_reg;
  logic [7:0]      rd_wdata_reg;
  logic            io_re_reg;
  logic            io_we_reg;
  logic [4:0]      io_addr_reg;
  logic [7:0]      io_wdata_reg;
  logic [2:0]      io_bit_reg;
  logic            io_set_reg;
  logic            accept;
  logic            taken;
  logic [7:0]      sh_result;
  logic            sh_carry;
  logic            sh_zero;
  logic            sh_neg;
  logic            sh_ovf;
  logic [4:0]      flag_op;

  function automatic logic is_branch(input cbf_op_t op);
    is_branch = (op >= op_branch_carry_one) && (op <= op_branch_irq_off);
  endfunction

  function automatic logic branch_hit(input cbf_op_t op,
                                      input logic [7:0] sr);
    unique case (op)
      op_branch_carry_one,
      op_branch_unsigned_lt:        branch_hit = sr[FLG_C];
      op_branch_carry_zero,
      op_branch_unsigned_ge:        branch_hit = !sr[FLG_C];
      op_branch_negative:           branch_hit = sr[FLG_N];
      op_branch_positive:           branch_hit = !sr[FLG_N];
      op_branch_signed_ge:
        branch_hit = !(sr[FLG_N] ^ sr[FLG_V]);
      op_branch_signed_lt:
        branch_hit = sr[FLG_N] ^ sr[FLG_V];
      op_branch_half_carry_one:     branch_hit = sr[FLG_H];
      op_branch_half_carry_zero:    branch_hit = !sr[FLG_H];
      op_branch_transfer_flag_one:  branch_hit = sr[FLG_T];
      op_branch_transfer_flag_zero: branch_hit = !sr[FLG_T];
      op_branch_overflow_one:       branch_hit = sr[FLG_V];
      op_branch_overflow_zero:      branch_hit = !sr[FLG_V];
      op_branch_irq_on:             branch_hit = sr[FLG_I];
      op_branch_irq_off:            branch_hit = !sr[FLG_I];
      default:                      branch_hit = 1'b0;
    endcase
  endfunction

  function automatic logic is_shift(input cbf_op_t op);
    is_shift = (op >= op_shift_left_logical) &&
               (op <= op_shift_right_signed);
  endfunction

  // Flag op decode: bit 4 valid, bit 3 value, bits 2:0 flag index
  function automatic logic [4:0] flag_cmd(input cbf_op_t op,
                                          input logic [2:0] s);
    unique case (op)
      op_flag_index_raise:    flag_cmd = {2'h3, s};
      op_flag_index_drop:     flag_cmd = {2'h2, s};
      op_carry_raise:         flag_cmd = {2'h3, FLG_C};
      op_carry_drop:          flag_cmd = {2'h2, FLG_C};
      op_negative_raise:      flag_cmd = {2'h3, FLG_N};
      op_negative_drop:       flag_cmd = {2'h2, FLG_N};
      op_zero_flag_raise:     flag_cmd = {2'h3, FLG_Z};
      op_zero_flag_drop:      flag_cmd = {2'h2, FLG_Z};
      op_transfer_flag_raise: flag_cmd = {2'h3, FLG_T};
      op_transfer_flag_drop:  flag_cmd = {2'h2, FLG_T};
      op_irq_enable_raise:    flag_cmd = {2'h3, FLG_I};
      op_irq_enable_drop:     flag_cmd = {2'h2, FLG_I};
      op_sign_test_raise:     flag_cmd = {2'h3, FLG_S};
      op_sign_test_drop:      flag_cmd = {2'h2, FLG_S};
      op_overflow_raise:      flag_cmd = {2'h3, FLG_V};
      op_overflow_drop:       flag_cmd = {2'h2, FLG_V};
      op_half_carry_raise:    flag_cmd = {2'h3, FLG_H};
      op_half_carry_drop:     flag_cmd = {2'h2, FLG_H};
      default:                flag_cmd = 5'h00;
    endcase
  endfunction

  assign accept = i_valid && ready_reg;
  assign taken  = accept && is_branch(i_op) && branch_hit(i_op, status_flags_register_reg);
  // Decoded once; a select on a call result is not legal syntax
  assign flag_op = flag_cmd(i_op, i_bit);

  cbf_shift u_shift (
    .i_op     (i_op),
    .i_data   (i_rd_data),
    .i_carry  (status_flags_register_reg[FLG_C]),
    .o_result (sh_result),
    .o_carry  (sh_carry),
    .o_zero   (sh_zero),
    .o_neg    (sh_neg),
    .o_ovf    (sh_ovf)
  );

  // Offset is a signed word count; wraps modulo the counter width
  always_comb
  begin
    pc_next = pc_reg + 16'h0001;
    if (taken)
      pc_next = pc_reg + {{(PC_W-7){i_k[6]}}, i_k} + 16'h0001;
  end

  // Sequencing: taken branches and I/O bit ops hold off the next op
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state_reg <= st_idle;
      ready_reg <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        st_idle:
          if (taken)
          begin
            state_reg <= st_branch;
            ready_reg <= 1'b0;
          end
          else if (accept && (i_op == op_io_bit_force_one ||
                              i_op == op_io_bit_force_zero))
          begin
            state_reg <= st_io_read;
            ready_reg <= 1'b0;
          end
        st_branch:
        begin
          state_reg <= st_idle;
          ready_reg <= 1'b1;
        end
        st_io_read:
        begin
          state_reg <= st_idle;
          ready_reg <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      pc_reg <= PC_RST;
    else if (accept)
      pc_reg <= pc_next;
  end

  // Status flags; branches and I/O ops never touch them
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      status_flags_register_reg <= STATUS_FLAGS_REGISTER_RST;
    else if (accept)
    begin
      if (is_shift(i_op))
      begin
        status_flags_register_reg[FLG_C] <= sh_carry;
        status_flags_register_reg[FLG_Z] <= sh_zero;
        status_flags_register_reg[FLG_N] <= sh_neg;
        status_flags_register_reg[FLG_V] <= sh_ovf;
      end
      else if (i_op == op_reg_bit_to_transfer_flag)
        status_flags_register_reg[FLG_T] <= i_rd_data[i_bit];
      else if (flag_op[4])
        status_flags_register_reg[flag_op[2:0]] <=
          flag_op[3];
    end
  end

  // Register write-back, one cycle after the op is taken
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      rd_we_reg    <= 1'b0;
      rd_wdata_reg <= 8'h00;
    end
    else
    begin
      rd_we_reg <= 1'b0;
      if (accept && (is_shift(i_op) || i_op == op_nibble_swap))
      begin
        rd_we_reg    <= 1'b1;
        rd_wdata_reg <= sh_result;
      end
      else if (accept && i_op == op_transfer_flag_to_reg_bit)
      begin
        rd_we_reg    <= 1'b1;
        rd_wdata_reg <= i_rd_data;
        rd_wdata_reg[i_bit] <= status_flags_register_reg[FLG_T];
      end
    end
  end

  // I/O read-modify-write: read in the first cycle, write in the second
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      io_re_reg    <= 1'b0;
      io_we_reg    <= 1'b0;
      io_addr_reg  <= 5'h00;
      io_wdata_reg <= 8'h00;
      io_bit_reg   <= 3'h0;
      io_set_reg   <= 1'b0;
    end
    else
    begin
      io_re_reg <= 1'b0;
      io_we_reg <= 1'b0;
      if (accept && (i_op == op_io_bit_force_one ||
                     i_op == op_io_bit_force_zero))
      begin
        io_re_reg   <= 1'b1;
        io_addr_reg <= i_io_addr;
        io_bit_reg  <= i_bit;
        io_set_reg  <= (i_op == op_io_bit_force_one);
      end
      else if (state_reg == st_io_read)
      begin
        io_we_reg    <= 1'b1;
        io_wdata_reg <= i_io_rdata;
        io_wdata_reg[io_bit_reg] <= io_set_reg;
      end
    end
  end

  assign o_ready    = ready_reg;
  assign o_pc       = pc_reg;
  assign o_status_flags_register     = status_flags_register_reg;
  assign o_rd_we    = rd_we_reg;
  assign o_rd_wdata = rd_wdata_reg;
  assign o_io_re    = io_re_reg;
  assign o_io_we    = io_we_reg;
  assign o_io_addr  = io_addr_reg;
  assign o_io_wdata = io_wdata_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_stall_one;
    !ready_reg ##1 ready_reg;
  endsequence

  property p_carry_taken;
    accept && i_op == op_branch_carry_one && status_flags_register_reg[FLG_C] |=>
      pc_reg == $past(pc_reg) + {{(PC_W-7){$past(i_k[6])}}, $past(i_k)}
      + 16'h0001 and s_stall_one;
  endproperty
  a_carry_taken: assert property (p_carry_taken)
    else $error("carry branch not taken correctly");

  property p_carry_skip;
    accept && i_op == op_branch_carry_zero && status_flags_register_reg[FLG_C] |=>
      ready_reg && pc_reg == $past(pc_reg) + 16'h0001;
  endproperty
  a_carry_skip: assert property (p_carry_skip)
    else $error("untaken carry branch misbehaved");

  property p_signed_ge;
    accept && i_op == op_branch_signed_ge &&
      (status_flags_register_reg[FLG_N] ^ status_flags_register_reg[FLG_V]) |=>
      ready_reg && pc_reg == $past(pc_reg) + 16'h0001;
  endproperty
  a_signed_ge: assert property (p_signed_ge)
    else $error("signed ge taken on N xor V set");

  property p_branch_flags;
    accept && is_branch(i_op) |=> status_flags_register_reg == $past(status_flags_register_reg);
  endproperty
  a_branch_flags: assert property (p_branch_flags)
    else $error("branch changed status flags");

  sequence s_io_rmw;
    io_re_reg && !ready_reg ##1 io_we_reg && ready_reg;
  endsequence

  property p_io_one;
    accept && i_op == op_io_bit_force_one |=> s_io_rmw ##0
      io_wdata_reg == ($past(i_io_rdata) | (8'h01 << $past(i_bit, 2)));
  endproperty
  a_io_one: assert property (p_io_one)
    else $error("I/O bit force one wrong");

  property p_io_zero;
    accept && i_op == op_io_bit_force_zero |=> s_io_rmw ##0
      io_wdata_reg == ($past(i_io_rdata) & ~(8'h01 << $past(i_bit, 2)));
  endproperty
  a_io_zero: assert property (p_io_zero)
    else $error("I/O bit force zero wrong");

  property p_lsl;
    accept && i_op == op_shift_left_logical |=> rd_we_reg &&
      rd_wdata_reg == {$past(i_rd_data[6:0]), 1'b0} &&
      status_flags_register_reg[FLG_C] == $past(i_rd_data[7]);
  endproperty
  a_lsl: assert property (p_lsl)
    else $error("logical left shift wrong");

  property p_asr;
    accept && i_op == op_shift_right_signed |=>
      rd_wdata_reg[7:6] == {2{$past(i_rd_data[7])}} &&
      status_flags_register_reg[FLG_C] == $past(i_rd_data[0]);
  endproperty
  a_asr: assert property (p_asr)
    else $error("signed right shift wrong");

  property p_swap;
    accept && i_op == op_nibble_swap |=> rd_we_reg &&
      rd_wdata_reg == {$past(i_rd_data[3:0]), $past(i_rd_data[7:4])} &&
      status_flags_register_reg == $past(status_flags_register_reg);
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");

  property p_bst;
    accept && i_op == op_reg_bit_to_transfer_flag |=>
      status_flags_register_reg[FLG_T] == $past(i_rd_data[i_bit]) && !rd_we_reg;
  endproperty
  a_bst: assert property (p_bst)
    else $error("bit store to T wrong");

  property p_irq_raise;
    accept && i_op == op_irq_enable_raise |=> status_flags_register_reg[FLG_I] &&
      status_flags_register_reg[6:0] == $past(status_flags_register_reg[6:0]);
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("interrupt enable raise wrong");

endmodule // cbf_exec

// ---- src/cbf_pkg.sv ----
// Constants, opcodes and states for the branch, bit and flag executor
// Operation
// - Carry branches jump PC+k+1 when carry matches; 1 cycle untaken, 2 taken
// - Signed branches test N xor V: ge when zero, lt when one
// - Half-carry branches jump PC+k+1 when H equals the tested value
// - Transfer-flag branches jump PC+k+1 when T matches; one or two cycles
// - Overflow branches jump PC+k+1 when V is one or zero as tested
// - Interrupt-state branches test I and jump; no flag changes
// - I/O bit force one sets bit b of location P in two cycles
// - I/O bit force zero clears bit b of location P in two cycles
// - Left shift and left rotate through carry; update Z, C, N, V
// - Right shift and right rotate through carry; update Z, C, N, V
// - Signed right shift keeps bit 7; updates Z, C, N, V in one cycle
// - Bit store copies Rr bit b into T, nothing else, one cycle
// - Bit load writes T into Rd bit b; flags unchanged; one cycle
// - Interrupt enable raise and drop set or clear I in one cycle
// - Sign test raise and drop force S only, one cycle
// - Overflow raise and drop force V only, one cycle
// - Half-carry raise and drop force H only, one cycle
package cbf_pkg;

  localparam int PC_W = 16;

  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  localparam logic [7:0]      STATUS_FLAGS_REGISTER_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST   = 16'h0000;

  typedef enum logic [5:0] {
    op_nop,
    op_branch_carry_one,
    op_branch_carry_zero,
    op_branch_unsigned_ge,
    op_branch_unsigned_lt,
    op_branch_negative,
    op_branch_positive,
    op_branch_signed_ge,
    op_branch_signed_lt,
    op_branch_half_carry_one,
    op_branch_half_carry_zero,
    op_branch_transfer_flag_one,
    op_branch_transfer_flag_zero,
    op_branch_overflow_one,
    op_branch_overflow_zero,
    op_branch_irq_on,
    op_branch_irq_off,
    op_io_bit_force_one,
    op_io_bit_force_zero,
    op_shift_left_logical,
    op_shift_right_logical,
    op_left_carry_rotate,
    op_right_carry_rotate,
    op_shift_right_signed,
    op_nibble_swap,
    op_flag_index_raise,
    op_flag_index_drop,
    op_reg_bit_to_transfer_flag,
    op_transfer_flag_to_reg_bit,
    op_carry_raise,
    op_carry_drop,
    op_negative_raise,
    op_negative_drop,
    op_zero_flag_raise,
    op_zero_flag_drop,
    op_irq_enable_raise,
    op_irq_enable_drop,
    op_sign_test_raise,
    op_sign_test_drop,
    op_overflow_raise,
    op_overflow_drop,
    op_transfer_flag_raise,
    op_transfer_flag_drop,
    op_half_carry_raise,
    op_half_carry_drop
  } cbf_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_branch,
    st_io_read
  } cbf_state_t;

endpackage

// ---- src/cbf_shift.sv ----
// Shift, rotate and nibble swap datapath with flag results
`timescale 1ns/1ps
module cbf_shift
  import cbf_pkg::*;
(
  input  cbf_pkg::cbf_op_t i_op,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_carry,
  output logic [7:0]       o_result,
  output logic             o_carry,
  output logic             o_zero,
  output logic             o_neg,
  output logic             o_ovf
);

  import cbf_pkg::*;

  always_comb
  begin
    o_result = i_data;
    o_carry  = i_carry;
    unique case (i_op)
      op_shift_left_logical:
      begin
        o_result = {i_data[6:0], 1'b0};
        o_carry  = i_data[7];
      end
      op_left_carry_rotate:
      begin
        o_result = {i_data[6:0], i_carry};
        o_carry  = i_data[7];
      end
      op_shift_right_logical:
      begin
        o_result = {1'b0, i_data[7:1]};
        o_carry  = i_data[0];
      end
      op_right_carry_rotate:
      begin
        o_result = {i_carry, i_data[7:1]};
        o_carry  = i_data[0];
      end
      op_shift_right_signed:
      begin
        o_result = {i_data[7], i_data[7:1]};
        o_carry  = i_data[0];
      end
      op_nibble_swap:
        o_result = {i_data[3:0], i_data[7:4]};
      default:
        o_result = i_data;
    endcase
    o_zero = (o_result == 8'h00);
    o_neg  = o_result[7];
    // Overflow after a shift is defined as N xor C
    o_ovf  = o_result[7] ^ o_carry;
  end

endmodule // cbf_shift

// ---- tb/cbf_exec_tb.sv ----
// Self-checking bench for the branch, bit and flag executor
`timescale 1ns/1ps
module cbf_exec_tb;
  import cbf_pkg::*;
  logic            i_clk;
  logic            i_reset_n;
  logic            i_valid;
  cbf_op_t         i_op;
  logic [6:0]      i_k;
  logic [2:0]      i_bit;
  logic [4:0]      i_io_addr;
  logic [7:0]      i_rd_data;
  logic [7:0]      i_io_rdata;
  logic            o_ready;
  logic [PC_W-1:0] o_pc;
  logic [7:0]      o_status_flags_register;
  logic            o_rd_we;
  logic [7:0]      o_rd_wdata;
  logic            o_io_re;
  logic            o_io_we;
  logic [4:0]      o_io_addr;
  logic [7:0]      o_io_wdata;
  logic [PC_W-1:0] exp_pc;
  logic [7:0]      exp_sr;
  int              n_mismatch;
  int              check_count;

  cbf_exec dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_valid(i_valid), .i_op(i_op),
    .i_k(i_k), .i_bit(i_bit), .i_io_addr(i_io_addr), .i_rd_data(i_rd_data),
    .i_io_rdata(i_io_rdata), .o_ready(o_ready), .o_pc(o_pc),
    .o_status_flags_register(o_status_flags_register), .o_rd_we(o_rd_we), .o_rd_wdata(o_rd_wdata),
    .o_io_re(o_io_re), .o_io_we(o_io_we), .o_io_addr(o_io_addr),
    .o_io_wdata(o_io_wdata)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] want,
                     input string what);
    check_count++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic core(input logic we);
    chk(o_pc, exp_pc, "pc");
    chk(16'(o_status_flags_register), 16'(exp_sr), "status_flags_register");
    chk(16'(o_rd_we), 16'(we), "rd_we");
  endtask

  // One request, taken at the second edge; returns mid-cycle after it
  task automatic go(input cbf_op_t op, input logic [6:0] k,
                    input logic [2:0] b, input logic [7:0] d);
    @(posedge i_clk);
    i_valid   <= 1'b1;
    i_op      <= op;
    i_k       <= k;
    i_bit     <= b;
    i_rd_data <= d;
    @(posedge i_clk);
    i_valid <= 1'b0;
    @(negedge i_clk);
    exp_pc = exp_pc + 16'h0001;
  endtask

  task automatic fl(input cbf_op_t op, input logic [2:0] f, input logic v);
    go(op, 7'h00, f, 8'h00);
    exp_sr[f] = v;
    core(1'b0);
  endtask

  task automatic br(input cbf_op_t op, input logic tk, input logic [6:0] k);
    go(op, k, 3'h0, 8'h00);
    if (tk)
      exp_pc = exp_pc + {{9{k[6]}}, k};
    core(1'b0);
    chk(16'(o_ready), 16'(!tk), "ready after branch");
    @(negedge i_clk);
    chk(16'(o_ready), 16'h0001, "ready restored");
  endtask

  task automatic t_branch();
    cbf_op_t    op;
    logic [2:0] fsel [16] = '{FLG_C, FLG_C, FLG_C, FLG_C, FLG_N, FLG_N,
                              FLG_C, FLG_C, FLG_H, FLG_H, FLG_T, FLG_T,
                              FLG_V, FLG_V, FLG_I, FLG_I};
    logic       pol [16] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
                             1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                             1'b1, 1'b0};
    logic       n;
    logic       v;
    for (int i = 0; i < 16; i++)
      if (i != 6 && i != 7)
        for (int s = 0; s < 2; s++)
        begin
          op = cbf_op_t'(int'(op_branch_carry_one) + i);
          fl(s[0] ? op_flag_index_raise : op_flag_index_drop, fsel[i], s[0]);
          br(op, s[0] == pol[i], s[0] ? 7'h3F : 7'h7E);
        end
    for (int j = 0; j < 4; j++)
    begin
      n = j[1];
      v = j[0];
      fl(n ? op_negative_raise : op_negative_drop, FLG_N, n);
      fl(v ? op_overflow_raise : op_overflow_drop, FLG_V, v);
      br(op_branch_signed_ge, !(n ^ v), 7'h40);
      br(op_branch_signed_lt, n ^ v, 7'h05);
    end
    $display("branch test done");
  endtask

  task automatic t_flags();
    logic [2:0] f [8] = '{FLG_C, FLG_N, FLG_Z, FLG_I,
                          FLG_S, FLG_V, FLG_T, FLG_H};
    cbf_op_t    op;
    for (int i = 0; i < 16; i++)
    begin
      op = cbf_op_t'(int'(op_carry_raise) + 2 * (i % 8) + i / 8);
      fl(op, f[i % 8], i < 8);
    end
    for (int i = 0; i < 8; i++)
      fl(i[0] ? op_flag_index_drop : op_flag_index_raise, 3'(i), !i[0]);
    $display("flag test done");
  endtask

  task automatic t_shift();
    logic [7:0] din [6] = '{8'h81, 8'h01, 8'h80, 8'h02, 8'h81, 8'h5A};
    logic       cin [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [7:0] d;
    logic [7:0] r;
    logic       c;
    fl(op_sign_test_raise, FLG_S, 1'b1);
    fl(op_half_carry_raise, FLG_H, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      d = din[i];
      fl(cin[i] ? op_carry_raise : op_carry_drop, FLG_C, cin[i]);
      go(cbf_op_t'(int'(op_shift_left_logical) + i), 7'h00, 3'h0, d);
      case (i)
        0: r = {d[6:0], 1'b0};
        1: r = {1'b0, d[7:1]};
        2: r = {d[6:0], cin[i]};
        3: r = {cin[i], d[7:1]};
        4: r = {d[7], d[7:1]};
        default: r = {d[3:0], d[7:4]};
      endcase
      c = (i == 0 || i == 2) ? d[7] : d[0];
      if (i < 5)
        exp_sr[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
      core(1'b1);
      chk(16'(o_rd_wdata), 16'(r), "shift result");
    end
    $display("shift test done");
  endtask

  task automatic t_bits();
    go(op_reg_bit_to_transfer_flag, 7'h00, 3'h5, 8'h20);
    exp_sr[FLG_T] = 1'b1;
    core(1'b0);
    go(op_transfer_flag_to_reg_bit, 7'h00, 3'h7, 8'h00);
    core(1'b1);
    chk(16'(o_rd_wdata), 16'h0080, "bit load one");
    go(op_reg_bit_to_transfer_flag, 7'h00, 3'h5, 8'hDF);
    exp_sr[FLG_T] = 1'b0;
    core(1'b0);
    go(op_transfer_flag_to_reg_bit, 7'h00, 3'h0, 8'hFF);
    core(1'b1);
    chk(16'(o_rd_wdata), 16'h00FE, "bit load zero");
    $display("bit transfer test done");
  endtask

  // Read data is only trusted in the cycle of the read pulse; it is inverted after that
  task automatic io(input cbf_op_t op, input logic [4:0] p,
                    input logic [2:0] b, input logic [7:0] rd,
                    input logic [7:0] want);
    @(posedge i_clk);
    i_io_addr  <= p;
    i_io_rdata <= rd;
    go(op, 7'h00, b, 8'h00);
    core(1'b0);
    chk(16'(o_io_re), 16'h0001, "io read pulse");
    chk(16'(o_io_addr), 16'(p), "io addr");
    chk(16'(o_ready), 16'h0000, "io busy");
    @(posedge i_clk);
    i_io_rdata <= ~rd;
    @(negedge i_clk);
    core(1'b0);
    chk(16'(o_io_re), 16'h0000, "io read once");
    chk(16'(o_io_we), 16'h0001, "io write pulse");
    chk(16'(o_io_addr), 16'(p), "io addr held");
    chk(16'(o_io_wdata), 16'(want), "io write data");
    chk(16'(o_ready), 16'h0001, "io ready");
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    n_mismatch  = 0;
    check_count = 0;
    i_reset_n   = 1'b0;
    i_valid     = 1'b0;
    i_op        = op_nop;
    i_k         = 7'h00;
    i_bit       = 3'h0;
    i_io_addr   = 5'h00;
    i_rd_data   = 8'h00;
    i_io_rdata  = 8'h00;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    exp_pc = PC_RST;
    exp_sr = STATUS_FLAGS_REGISTER_RST;
    core(1'b0);
    chk(16'(o_ready), 16'h0001, "ready after reset");
    $display("reset test done");
    t_flags();
    t_branch();
    t_shift();
    t_bits();
    io(op_io_bit_force_one, 5'h1F, 3'h2, 8'h00, 8'h04);
    io(op_io_bit_force_zero, 5'h05, 3'h7, 8'hFF, 8'h7F);
    $display("io test done");
    tally_and_finish();
  end
endmodule // cbf_exec_tb
